//--- pao_top.sv
// How it works
// - Coding select low inverts MSB: two's complement
// - Enable low drives word and flag outputs, high floats them
// - Twelve-bit word, bit 0 LSB, bit 11 MSB
// - Flag high when input beyond valid range
// - Encode high when true input exceeds complement
// - Track input while low, hold while high
// - Each encode rising edge takes one sample
// - Result appears five encode cycles after sampling
// - Four stages, alternate phases, aligned partial results
package pao_pkg;

  localparam int WORD_W     = 12;  // Output word width
  localparam int AIN_W      = 14;  // Digitised stand-in for the analog input
  localparam int STG_W      = 3;   // Bits resolved per stage
  localparam int N_STAGES   = 4;
  localparam int LATENCY    = 5;   // Encode cycles, sample to output
  localparam int STG_DONE   = 2;   // Rising edge at which stage four is done
  localparam int DLY_N      = LATENCY - STG_DONE - 1;
  localparam int XFER_W     = WORD_W + 1;  // Word plus range flag
  localparam int FIFO_DEPTH = 8;
  localparam int SYNC_N     = 3;   // Flip-flops on every foreign input
  localparam int MSB_POS    = WORD_W - 1;
  localparam int OVF_POS    = WORD_W;
  localparam logic [WORD_W-1:0] WORD_TOP = 12'hFFF;
  localparam logic [WORD_W-1:0] WORD_BOT = 12'h000;

  typedef enum logic [1:0] {
    PAO_IDLE,
    PAO_SETUP,
    PAO_STROBE,
    PAO_DONE
  } pao_lnk_state_t;

  // Core domain state, encode sampling and pipeline
  typedef struct packed {
    logic [SYNC_N-1:0]             enc_t_s;
    logic [SYNC_N-1:0]             enc_c_s;
    logic                          enc_t_ag;
    logic                          enc_c_ag;
    logic [SYNC_N-1:0]             cs_s;
    logic                          cs_ag;
    logic [SYNC_N-1:0][AIN_W-1:0]  ain_s;
    logic [AIN_W-1:0]              ain_ag;
    logic [WORD_W-1:0]             trk;
    logic                          trk_ovf;
    logic [WORD_W-1:0]             hold;
    logic                          hold_ovf;
    logic                          hold_v;
    logic [STG_W-1:0]              s1_q;
    logic [WORD_W-STG_W-1:0]       s1_res;
    logic                          s1_ovf;
    logic                          s1_v;
    logic [2*STG_W-1:0]            s2_q;
    logic [WORD_W-2*STG_W-1:0]     s2_res;
    logic                          s2_ovf;
    logic                          s2_v;
    logic [3*STG_W-1:0]            s3_q;
    logic [WORD_W-3*STG_W-1:0]     s3_res;
    logic                          s3_ovf;
    logic                          s3_v;
    logic [DLY_N:0][XFER_W-1:0]    dly;
    logic [DLY_N:0]                dly_v;
    logic [XFER_W-1:0]             xfer;
    logic                          req;
    logic [SYNC_N-1:0]             ack_s;
    logic                          ack_ag;
    logic                          lost;
  } pao_core_t;

  // Link domain state, facing the capture logic
  typedef struct packed {
    logic [SYNC_N-1:0] rst_s;
    logic [SYNC_N-1:0] req_s;
    logic              req_ag;
    logic              ack;
    logic [SYNC_N-1:0] oe_s;
    logic              oe_n_ag;
    pao_lnk_state_t    st;
    logic [WORD_W-1:0] word;
    logic              ovf;
    logic              strobe;
    logic              drive;
  } pao_lnk_t;

endpackage

`timescale 1ns/1ns

module pao_top
  import pao_pkg::*;
(
  input  wire logic                    clk_in,
  input  wire logic                    srst_in,
  input  wire logic                    lnk_clk_in,
  input  wire logic                    enc_true_in,
  input  wire logic                    enc_comp_in,
  input  wire logic signed [AIN_W-1:0] ain_diff_in,
  input  wire logic                    coding_select_in,
  input  wire logic                    out_enable_n_in,
  output logic [WORD_W-1:0]            sample_word_out,
  output logic                         sample_word_oe_out,
  output logic                         range_overflow_flag_out,
  output logic                         range_overflow_flag_oe_out,
  output logic                         data_valid_strobe_out,
  output logic                         sample_lost_out
);

  pao_core_t         core_r;
  pao_core_t         core_nxt;
  pao_lnk_t          lnk_r;
  pao_lnk_t          lnk_nxt;
  logic              lnk_rst;
  logic              fifo_in_valid;
  logic [XFER_W-1:0] fifo_in_data;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic [XFER_W-1:0] fifo_out_data;
  logic              fifo_out_ready;
  logic              enc_lvl;
  logic              enc_rise;
  logic              enc_fall;
  logic              xfer_busy;
  logic [WORD_W-1:0] ain_code;
  logic              ain_ovf;
  logic [XFER_W-1:0] last;
  logic              msb_coded;
  logic              enc_t_nx;
  logic              enc_c_nx;
  logic              enc_lvl_nx;

  // Input quantiser: clamp to full scale, offset binary inside
  // The analog input is a digital stand-in, read from its word synchroniser
  always_comb begin
    ain_ovf  = 1'b0;
    ain_code = {~core_r.ain_ag[MSB_POS], core_r.ain_ag[MSB_POS-1:0]};
    if (core_r.ain_ag[AIN_W-1:MSB_POS] != {(AIN_W-MSB_POS){core_r.ain_ag[AIN_W-1]}}) begin
      ain_ovf  = 1'b1;
      ain_code = core_r.ain_ag[AIN_W-1] ? WORD_BOT : WORD_TOP;
    end
  end

  // Agreed encode pins one edge ahead, straight from the synchronisers;
  // kept out of core_nxt so the edge detect forms no loop through the state
  assign enc_t_nx   = (core_r.enc_t_s[1] == core_r.enc_t_s[2]) ? core_r.enc_t_s[2]
                                                                : core_r.enc_t_ag;
  assign enc_c_nx   = (core_r.enc_c_s[1] == core_r.enc_c_s[2]) ? core_r.enc_c_s[2]
                                                                : core_r.enc_c_ag;

  // Phase events from the agreed encode pair; compare true against complement
  assign enc_lvl    = core_r.enc_t_ag & ~core_r.enc_c_ag;
  assign enc_lvl_nx = enc_t_nx & ~enc_c_nx;
  assign enc_rise   = ~enc_lvl & enc_lvl_nx;
  assign enc_fall   = enc_lvl & ~enc_lvl_nx;

  // Oldest alignment slot leaves on the fifth rise, MSB coding applied last
  assign last          = core_r.dly[DLY_N];
  assign fifo_in_valid = enc_rise & core_r.dly_v[DLY_N];
  // Coding read at push time, so words already queued keep theirs
  assign msb_coded     = last[MSB_POS] ^ ~core_r.cs_ag;
  assign fifo_in_data  = {last[OVF_POS], msb_coded, last[MSB_POS-1:0]};
  assign xfer_busy      = core_r.req != core_r.ack_ag;
  assign fifo_out_ready = ~xfer_busy;

  // Core domain next state
  always_comb begin
    core_nxt = core_r;

    // Three-stage synchronisers; a change counts when stages two and three agree
    core_nxt.enc_t_s = {core_r.enc_t_s[SYNC_N-2:0], enc_true_in};
    core_nxt.enc_c_s = {core_r.enc_c_s[SYNC_N-2:0], enc_comp_in};
    core_nxt.cs_s    = {core_r.cs_s[SYNC_N-2:0], coding_select_in};
    core_nxt.ack_s   = {core_r.ack_s[SYNC_N-2:0], lnk_r.ack};
    core_nxt.ain_s   = {core_r.ain_s[SYNC_N-2:0], ain_diff_in};
    core_nxt.enc_t_ag = enc_t_nx;
    core_nxt.enc_c_ag = enc_c_nx;
    // The input word counts only once stages two and three agree on every bit
    if (core_r.ain_s[1] == core_r.ain_s[2]) begin
      core_nxt.ain_ag = core_r.ain_s[2];
    end
    if (core_r.cs_s[1] == core_r.cs_s[2]) begin
      core_nxt.cs_ag = core_r.cs_s[2];
    end
    if (core_r.ack_s[1] == core_r.ack_s[2]) begin
      core_nxt.ack_ag = core_r.ack_s[2];
    end

    // Track phase: follow the input only while encode is low
    if (!enc_lvl) begin
      core_nxt.trk     = ain_code;
      core_nxt.trk_ovf = ain_ovf;
    end

    // Pipeline walk for one sample, counted in agreed encode rises:
    //   rise 0  hold takes the tracked code
    //   fall 0  stage one splits off the top three bits
    //   rise 1  stage two adds the next three
    //   fall 1  stage three adds three more
    //   rise 2  stage four resolves the rest into the correction word
    //   rise 3  alignment slot one
    //   rise 4  alignment slot two
    //   rise 5  word enters the buffer with its flag
    // Valid bits start clear, so the first five rises push nothing stale
    // Rising edge: hold sample, run even stages and the alignment line
    if (enc_rise) begin
      core_nxt.hold     = core_r.trk;
      core_nxt.hold_ovf = core_r.trk_ovf;
      core_nxt.hold_v   = 1'b1;
      core_nxt.s2_q     = {core_r.s1_q, core_r.s1_res[WORD_W-STG_W-1 -: STG_W]};
      core_nxt.s2_res   = core_r.s1_res[WORD_W-2*STG_W-1:0];
      core_nxt.s2_ovf   = core_r.s1_ovf;
      core_nxt.s2_v     = core_r.s1_v;
      // Stage four result joins the others in the correction word
      core_nxt.dly[0]   = {core_r.s3_ovf, core_r.s3_q, core_r.s3_res};
      core_nxt.dly_v[0] = core_r.s3_v;
      for (int i = 1; i <= DLY_N; i++) begin
        core_nxt.dly[i]   = core_r.dly[i-1];
        core_nxt.dly_v[i] = core_r.dly_v[i-1];
      end
      // A full FIFO cannot take the word; the loss is reported, not hidden
      if (fifo_in_valid && !fifo_in_ready) begin
        core_nxt.lost = 1'b1;
      end
    end

    // Falling edge: odd stages acquire the previous residue
    if (enc_fall) begin
      core_nxt.s1_q   = core_r.hold[MSB_POS -: STG_W];
      core_nxt.s1_res = core_r.hold[WORD_W-STG_W-1:0];
      core_nxt.s1_ovf = core_r.hold_ovf;
      core_nxt.s1_v   = core_r.hold_v;
      core_nxt.s3_q   = {core_r.s2_q, core_r.s2_res[WORD_W-2*STG_W-1 -: STG_W]};
      core_nxt.s3_res = core_r.s2_res[WORD_W-3*STG_W-1:0];
      core_nxt.s3_ovf = core_r.s2_ovf;
      core_nxt.s3_v   = core_r.s2_v;
    end

    // Toggle handshake toward the link; word stays put until acknowledged
    if (fifo_out_valid && !xfer_busy) begin
      core_nxt.xfer = fifo_out_data;
      core_nxt.req  = ~core_r.req;
    end
  end

  // Reset is the only way the lost flag returns to zero
  // Core state register
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      core_r <= '0;
    end else begin
      core_r <= core_nxt;
    end
  end

  // Eight-word buffer between the converter core and the link
  pao_fifo #(
    .W     (XFER_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .srst_in       (srst_in),
    .in_valid_in   (fifo_in_valid),
    .in_data_in    (fifo_in_data),
    .in_ready_out  (fifo_in_ready),
    .out_valid_out (fifo_out_valid),
    .out_data_out  (fifo_out_data),
    .out_ready_in  (fifo_out_ready)
  );

  // Link reset follows the core reset once two stages agree it is high
  assign lnk_rst = lnk_r.rst_s[1] & lnk_r.rst_s[2];

  // Link walk: idle sees a fresh request and loads word and flag,
  // the strobe rises one cycle later, then acknowledge and back to idle.
  // The word is read across domains only after the request has settled,
  // and the core cannot move it until the acknowledge returns.
  // Link domain next state
  always_comb begin
    lnk_nxt       = lnk_r;
    lnk_nxt.rst_s = {lnk_r.rst_s[SYNC_N-2:0], srst_in};
    lnk_nxt.req_s = {lnk_r.req_s[SYNC_N-2:0], core_r.req};
    lnk_nxt.oe_s  = {lnk_r.oe_s[SYNC_N-2:0], out_enable_n_in};
    if (lnk_r.req_s[1] == lnk_r.req_s[2]) begin
      lnk_nxt.req_ag = lnk_r.req_s[2];
    end
    if (lnk_r.oe_s[1] == lnk_r.oe_s[2]) begin
      lnk_nxt.oe_n_ag = lnk_r.oe_s[2];
    end
    // Drive only while the active-low enable is agreed low
    lnk_nxt.drive = ~lnk_nxt.oe_n_ag;

    case (lnk_r.st)
      PAO_IDLE: begin
        // Core word is stable by now; the request crossed three stages
        if (lnk_r.req_ag != lnk_r.ack) begin
          lnk_nxt.word = core_r.xfer[WORD_W-1:0];
          lnk_nxt.ovf  = core_r.xfer[OVF_POS];
          lnk_nxt.st   = PAO_SETUP;
        end
      end
      PAO_SETUP: begin
        // One link cycle of setup before the rising strobe edge
        lnk_nxt.strobe = 1'b1;
        lnk_nxt.st     = PAO_STROBE;
      end
      PAO_STROBE: begin
        lnk_nxt.strobe = 1'b0;
        lnk_nxt.ack    = ~lnk_r.ack;
        lnk_nxt.st     = PAO_DONE;
      end
      PAO_DONE: begin
        // One link cycle, then idle; another word waits for the core's next request toggle
        lnk_nxt.st = PAO_IDLE;
      end
      default: begin
        lnk_nxt.strobe = 1'b0;
        lnk_nxt.st     = PAO_IDLE;
      end
    endcase
  end

  // Link state register; enable and reset synchroniser stages keep running through reset
  always_ff @(posedge lnk_clk_in) begin
    if (lnk_rst) begin
      // Enable and reset stages keep shifting, so the first cycle out of
      // reset already sees the true pin levels and makes no false edge
      lnk_r       <= '0;
      lnk_r.rst_s <= lnk_nxt.rst_s;
      lnk_r.oe_s  <= lnk_nxt.oe_s;
    end else begin
      lnk_r <= lnk_nxt;
    end
  end

  // Pin outputs straight from flip-flops
  assign sample_word_out            = lnk_r.word;
  assign range_overflow_flag_out    = lnk_r.ovf;
  assign sample_word_oe_out         = lnk_r.drive;
  assign range_overflow_flag_oe_out = lnk_r.drive;
  assign data_valid_strobe_out      = lnk_r.strobe;
  assign sample_lost_out            = core_r.lost;

endmodule // pao_top

//--- pao_fifo.sv
`timescale 1ns/1ns

// Small synchronous FIFO, flip-flop storage, valid/ready on both sides.
// DEPTH is expected to be a power of two so the pointers wrap naturally.
module pao_fifo #(
  parameter int W     = 13,
  parameter int DEPTH = 8
) (
  input  wire logic         clk_in,
  input  wire logic         srst_in,
  input  wire logic         in_valid_in,
  input  wire logic [W-1:0] in_data_in,
  output logic              in_ready_out,
  output logic              out_valid_out,
  output logic [W-1:0]      out_data_out,
  input  wire logic         out_ready_in
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wr;
    logic [AW-1:0]           rd;
    logic [AW:0]             cnt;
  } pao_fifo_t;

  pao_fifo_t st_r;
  pao_fifo_t st_nxt;
  logic      push;
  logic      pop;

  // Honest flags straight from the occupancy count
  assign in_ready_out  = (st_r.cnt != FULL_CNT);
  assign out_valid_out = (st_r.cnt != '0);
  assign out_data_out  = st_r.mem[st_r.rd];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  // Next state: write at wr, read at rd, count tracks both
  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wr] = in_data_in;
      st_nxt.wr           = st_r.wr + 1'b1;
    end
    if (pop) begin
      st_nxt.rd = st_r.rd + 1'b1;
    end
    case ({push, pop})
      2'b10:   st_nxt.cnt = st_r.cnt + 1'b1;
      2'b01:   st_nxt.cnt = st_r.cnt - 1'b1;
      default: st_nxt.cnt = st_r.cnt;
    endcase
  end

  // Single state register
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule // pao_fifo

//--- pao_top_sva.sv
`timescale 1ns/1ns

module pao_top_sva
  import pao_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              srst_in,
  input  wire logic              lnk_clk_in,
  input  wire logic              out_enable_n_in,
  input  wire logic [WORD_W-1:0] sample_word_out,
  input  wire logic              sample_word_oe_out,
  input  wire logic              range_overflow_flag_oe_out,
  input  wire logic              range_overflow_flag_out,
  input  wire logic              data_valid_strobe_out,
  input  wire logic              sample_lost_out
);
  // Word and flag pins share one enable
  property p_oe_pair;
    @(posedge lnk_clk_in) disable iff (srst_in)
      sample_word_oe_out == range_overflow_flag_oe_out;
  endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("enables differ");
  // Eight link cycles cover the enable synchroniser
  property p_oe_off;
    @(posedge lnk_clk_in) disable iff (srst_in) out_enable_n_in [*8] |-> !sample_word_oe_out;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("outputs driven while disabled");
  property p_oe_on;
    @(posedge lnk_clk_in) disable iff (srst_in)
      (!out_enable_n_in && !srst_in) [*8] |-> sample_word_oe_out;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("outputs floating while enabled");
  // Strobe is a single link cycle wide
  property p_strobe_one;
    @(posedge lnk_clk_in) disable iff (srst_in) $rose(data_valid_strobe_out) |=> !data_valid_strobe_out;
  endproperty
  a_strobe_one: assert property (p_strobe_one) else $error("strobe too long");
  // Word and flag already settled when the strobe rises
  property p_word_hold;
    @(posedge lnk_clk_in) disable iff (srst_in) data_valid_strobe_out |->
      $stable(sample_word_out) && $stable(range_overflow_flag_out);
  endproperty
  a_word_hold: assert property (p_word_hold) else $error("word moved at strobe");
  // One strobe per word, so at least two quiet cycles follow
  property p_strobe_gap;
    @(posedge lnk_clk_in) disable iff (srst_in) data_valid_strobe_out |=> !data_valid_strobe_out [*2];
  endproperty
  a_strobe_gap: assert property (p_strobe_gap) else $error("strobes too close");
  // A flagged word is a clamped full-scale code
  property p_flag_clamp;
    @(posedge lnk_clk_in) disable iff (srst_in) data_valid_strobe_out && range_overflow_flag_out |->
      sample_word_out[WORD_W-2:0] == 11'h7FF || sample_word_out[WORD_W-2:0] == 11'h000;
  endproperty
  a_flag_clamp: assert property (p_flag_clamp) else $error("flag without clamp");
  property p_lost_sticky;
    @(posedge clk_in) disable iff (srst_in) sample_lost_out |=> sample_lost_out;
  endproperty
  a_lost_sticky: assert property (p_lost_sticky) else $error("lost flag dropped");
endmodule // pao_top_sva

bind pao_top pao_top_sva u_sva (.clk_in(clk_in), .srst_in(srst_in), .lnk_clk_in(lnk_clk_in),
  .out_enable_n_in(out_enable_n_in), .sample_word_out(sample_word_out),
  .sample_word_oe_out(sample_word_oe_out), .range_overflow_flag_oe_out(range_overflow_flag_oe_out),
  .range_overflow_flag_out(range_overflow_flag_out),
  .data_valid_strobe_out(data_valid_strobe_out), .sample_lost_out(sample_lost_out));

//--- pao_cap_model.sv
`timescale 1ns/1ns

module pao_cap_model
  import pao_pkg::*;
(
  input  wire logic              lnk_clk_in,
  input  wire logic              strobe_in,
  input  wire logic [WORD_W-1:0] word_in,
  input  wire logic              flag_in,
  output logic                   cap_valid_out,
  output logic [WORD_W-1:0]      cap_word_out,
  output logic                   cap_flag_out
);
  logic strobe_r = 1'b0;
  initial cap_valid_out = 1'b0;
  // Latch on the strobe's rising edge only, never while it stays high
  always @(posedge lnk_clk_in) begin
    strobe_r      <= strobe_in;
    cap_valid_out <= strobe_in && !strobe_r;
    if (strobe_in && !strobe_r) begin
      cap_word_out <= word_in;
      cap_flag_out <= flag_in;
    end
  end
endmodule // pao_cap_model

//--- testbench.sv
`timescale 1ns/1ns

module testbench
  import pao_pkg::*;
;
  typedef struct {logic signed [AIN_W-1:0] a; logic cs; logic [XFER_W-1:0] x;} pao_row_t;
  logic clk_in = 1'b0, lnk_clk_in = 1'b0, srst_in = 1'b1;
  logic enc_true_in = 1'b0, enc_comp_in = 1'b1, coding_select_in = 1'b1, out_enable_n_in = 1'b0;
  logic signed [AIN_W-1:0] ain_diff_in = '0;
  logic [WORD_W-1:0] word, cap_word;
  logic              word_oe, flag, flag_oe, strobe, lost, cap_v, cap_flag;
  logic [XFER_W-1:0] exp_q[$];
  logic [XFER_W-1:0] exp_x;
  int                failures = 0, total_checks = 0, cyc = 0;
  bit                chk_on = 0;
  // Sample, coding at push time, expected {flag, word}
  pao_row_t rows[11] = '{'{14'sh0000, 1, 13'h0800}, '{14'sh0000, 0, 13'h0000},
    '{14'sh07FF, 1, 13'h0FFF}, '{14'sh07FF, 0, 13'h07FF}, '{14'sh3800, 1, 13'h0000},
    '{14'sh3800, 0, 13'h0800}, '{14'sh0BB8, 1, 13'h1FFF}, '{14'sh3448, 0, 13'h1800},
    '{14'sh0800, 0, 13'h17FF}, '{14'sh3FFF, 1, 13'h07FF}, '{14'sh0123, 0, 13'h0123}};

  always #10 clk_in = ~clk_in;
  // Link clock, half periods of 62 and 63 ns keep it out of phase with the core
  always begin
    #62 lnk_clk_in = 1'b1;
    #63 lnk_clk_in = 1'b0;
  end

  pao_top dut (.clk_in(clk_in), .srst_in(srst_in), .lnk_clk_in(lnk_clk_in),
    .enc_true_in(enc_true_in), .enc_comp_in(enc_comp_in), .ain_diff_in(ain_diff_in),
    .coding_select_in(coding_select_in), .out_enable_n_in(out_enable_n_in),
    .sample_word_out(word), .sample_word_oe_out(word_oe), .range_overflow_flag_out(flag),
    .range_overflow_flag_oe_out(flag_oe), .data_valid_strobe_out(strobe),
    .sample_lost_out(lost));
  // A floating bus shows the inverse, not a stale value
  pao_cap_model u_cap (.lnk_clk_in(lnk_clk_in), .strobe_in(strobe),
    .word_in(word_oe ? word : ~word), .flag_in(flag_oe ? flag : ~flag),
    .cap_valid_out(cap_v), .cap_word_out(cap_word), .cap_flag_out(cap_flag));

  task automatic chk_word(input string n, input logic [WORD_W-1:0] e, input logic [WORD_W-1:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %b seen %b", n, e, g);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One encode period: low phase with a false pulse, then rise and a held phase
  task automatic enc_cycle(input logic signed [AIN_W-1:0] a, input logic c, input int half);
    @(posedge clk_in);
    ain_diff_in <= a;
    coding_select_in <= c;
    repeat (half / 4) @(posedge clk_in);
    enc_true_in <= 1'b1;
    repeat (half / 4) @(posedge clk_in);
    enc_true_in <= 1'b0;
    repeat (half / 2) @(posedge clk_in);
    enc_true_in <= 1'b1;
    enc_comp_in <= 1'b0;
    repeat (half / 2) @(posedge clk_in);
    ain_diff_in <= 14'sh1555;
    repeat (half / 2) @(posedge clk_in);
    enc_true_in <= 1'b0;
    enc_comp_in <= 1'b1;
  endtask

  // Captured words against the expected stream, in order
  always @(posedge lnk_clk_in) begin
    if (cap_v && chk_on) begin
      if (exp_q.size() == 0) chk_bit("surplus word", 1'b0, 1'b1);
      else begin
        exp_x = exp_q.pop_front();
        chk_word("sample word", exp_x[WORD_W-1:0], cap_word);
        chk_bit("range flag", exp_x[OVF_POS], cap_flag);
      end
    end
  end

  // Hang guard, well above the expected run length
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      failures++;
      $display("Error timeout expected finish seen hang");
      report_and_stop;
    end
  end

  initial begin
    repeat (8) @(posedge lnk_clk_in);
    @(posedge clk_in) srst_in <= 1'b0;
    @(negedge clk_in);
    chk_word("word after reset", 12'h000, word);
    chk_bit("strobe after reset", 1'b0, strobe);
    repeat (10) @(posedge lnk_clk_in);
    chk_bit("word enable", 1'b1, word_oe);
    chk_on = 1;
    // Row k is pushed five rises later, with the coding set then
    for (int k = 0; k < 16; k++) begin
      if (k >= 5) exp_q.push_back(rows[k-5].x);
      enc_cycle(k < 11 ? rows[k].a : 14'sh0000, k >= 5 ? rows[k-5].cs : 1'b1, 20);
    end
    for (int i = 0; i < 300 && exp_q.size() > 0; i++) @(posedge lnk_clk_in);
    repeat (20) @(posedge lnk_clk_in);
    chk_bit("all words seen", 1'b1, exp_q.size() == 0);
    chk_on = 0;
    @(posedge clk_in) out_enable_n_in <= 1'b1;
    repeat (10) @(posedge lnk_clk_in);
    chk_bit("word enable off", 1'b0, word_oe);
    chk_bit("flag enable off", 1'b0, flag_oe);
    @(posedge clk_in) out_enable_n_in <= 1'b0;
    repeat (10) @(posedge lnk_clk_in);
    chk_bit("flag enable on", 1'b1, flag_oe);
    chk_bit("lost before burst", 1'b0, lost);
    // Encode far faster than the link drains: the buffer must overflow
    repeat (40) enc_cycle(14'sh0100, 1'b1, 4);
    chk_bit("lost after burst", 1'b1, lost);
    @(posedge clk_in) srst_in <= 1'b1;
    repeat (8) @(posedge lnk_clk_in);
    @(posedge clk_in) srst_in <= 1'b0;
    @(negedge clk_in);
    chk_bit("lost after reset", 1'b0, lost);
    report_and_stop;
  end
endmodule // testbench
